// ===== verilog/sbs_core.sv
// Burst memory core with pin port and control registers
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module sbs_core
    import sbs_pkg::*;
#(
    parameter int ADDR_W = SBS_ADDR_W
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,

    // Address and access control pins
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic strobe_processor_n,
    input wire logic strobe_cache_n,
    input wire logic burst_step_n,
    input wire logic byte_write_enable_n,
    input wire logic all_bytes_write_n,
    input wire logic [SBS_LANES-1:0] lane_write_n,
    input wire logic output_enable_n,

    // Mode pins
    input wire logic flow_through_select_n,
    input wire logic linear_order_n,
    input wire logic sleep_request,

    // Data pins, lanes 0 to 3 low byte first
    input wire logic [SBS_DATA_W-1:0] data_in,
    output logic [SBS_DATA_W-1:0] data_out,
    output logic [SBS_LANES-1:0] data_oe_n,

    // AXI4-Lite write channels
    input wire logic [SBS_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,

    // AXI4-Lite read channels
    input wire logic [SBS_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int DEPTH = 1 << ADDR_W;

    if (ADDR_W < 3 || ADDR_W > 20) begin : g_check
        $error("sbs_core needs ADDR_W between 3 and 20");
    end

    // ==========================================================
    // Mode straps
    logic [SBS_STRAP_W-1:0] strap;
    logic pipelined;
    logic interleaved;
    logic soft_sleep;
    logic asleep_now;

    // Straps, reset to their pin defaults
    sbs_sync #(
        .WIDTH(SBS_STRAP_W),
        .RESET_VAL(SBS_STRAP_RESET)
    ) u_strap_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_level({sleep_request, linear_order_n, flow_through_select_n}),
        .level(strap)
    );

    // Decode the synchronised flow and order straps; sleep uses the raw pin or soft_sleep
    always_comb begin
        pipelined = strap[SBS_STRAP_FT_BIT];
        interleaved = strap[SBS_STRAP_LBO_BIT];
        asleep_now = sleep_request | soft_sleep;
    end

    // ==========================================================
    // Access decode
    sbs_burst_if bif ();
    sbs_op_type op;
    logic selected;
    logic begin_burst;
    logic [SBS_LANES-1:0] lanes;
    logic [ADDR_W-1:0] access_addr;
    logic live;
    logic [ADDR_W-3:0] upper;

    sbs_burst_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .bif(bif)
    );

    // Decode this cycle's access
    always_comb begin
        selected = !chip_select_first_n && chip_select_second && !chip_select_third_n;
        if (!all_bytes_write_n) begin
            lanes = SBS_LANES_ALL;
        end else if (!byte_write_enable_n) begin
            lanes = ~lane_write_n;
        end else begin
            lanes = SBS_LANES_NONE;
        end
        op = SBS_OP_IDLE;
        begin_burst = 1'b0;
        bif.step = 1'b0;
        if (asleep_now) begin
            op = SBS_OP_IDLE;
        end else if (!strobe_processor_n && !chip_select_first_n) begin
            op = selected ? SBS_OP_READ : SBS_OP_DESELECT;
            begin_burst = selected;
        end else if (!strobe_cache_n) begin
            if (!selected) begin
                op = SBS_OP_DESELECT;
            end else if (lanes != SBS_LANES_NONE) begin
                op = SBS_OP_WRITE;
            end else begin
                op = SBS_OP_READ;
            end
            begin_burst = selected;
        end else if (live) begin
            op = (lanes != SBS_LANES_NONE) ? SBS_OP_WRITE : SBS_OP_READ;
            bif.step = !burst_step_n;
        end
        bif.load = begin_burst;
        bif.start_low = addr[1:0];
        bif.linear = !interleaved;
        if (begin_burst) begin
            access_addr = addr;
        end else begin
            access_addr = {upper, bif.low_now};
        end
    end

    // ==========================================================
    // Burst tracking
    logic next_live;
    logic [ADDR_W-3:0] next_upper;

    // Upper address held for the burst
    always_comb begin
        next_live = live;
        next_upper = upper;
        if (begin_burst) begin
            next_live = 1'b1;
            next_upper = addr[ADDR_W-1:2];
        end else if (op == SBS_OP_DESELECT) begin
            next_live = 1'b0;
        end
    end

    // Register burst tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            live <= 1'b0;
            upper <= '0;
        end else begin
            live <= next_live;
            upper <= next_upper;
        end
    end

    // ==========================================================
    // Storage array, kept through sleep
    logic [SBS_DATA_W-1:0] mem [DEPTH];

    // Write enabled lanes at the edge
    always_ff @(posedge aclk) begin
        if (op == SBS_OP_WRITE) begin
            for (int l = 0; l < SBS_LANES; l++) begin
                if (lanes[l]) begin
                    mem[access_addr][l*SBS_LANE_W +: SBS_LANE_W] <=
                        data_in[l*SBS_LANE_W +: SBS_LANE_W];
                end
            end
        end
    end

    // ==========================================================
    // Read path and driver control
    logic [ADDR_W-1:0] rd_addr;
    logic read_q;
    logic drive;
    logic [SBS_DATA_W-1:0] out_reg;
    logic [ADDR_W-1:0] next_rd_addr;
    logic next_read_q;
    logic next_drive;
    logic [SBS_DATA_W-1:0] next_out_reg;
    logic stop_drive;

    // Reads take one stage, pipelined two
    always_comb begin
        next_rd_addr = (op == SBS_OP_READ) ? access_addr : rd_addr;
        next_read_q = (op == SBS_OP_READ);
        next_out_reg = read_q ? mem[rd_addr] : out_reg;
        stop_drive = (op == SBS_OP_DESELECT) || (op == SBS_OP_WRITE);
        if (pipelined) begin
            next_drive = read_q && !stop_drive;
        end else begin
            next_drive = (op == SBS_OP_READ);
        end
    end

    // Register the read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr <= '0;
            read_q <= 1'b0;
            drive <= 1'b0;
            out_reg <= '0;
        end else begin
            rd_addr <= next_rd_addr;
            read_q <= next_read_q;
            drive <= next_drive;
            out_reg <= next_out_reg;
        end
    end

    // Data and enables, gated without the clock
    always_comb begin
        if (!drive) begin
            data_out = '0;
        end else if (pipelined) begin
            data_out = out_reg;
        end else begin
            data_out = mem[rd_addr];
        end
        data_oe_n = {SBS_LANES{!(drive && !output_enable_n && !sleep_request)}};
    end

    // ==========================================================
    // Control register slave
    logic aw_have;
    logic w_have;
    logic [SBS_AXI_AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic next_aw_have;
    logic next_w_have;
    logic [SBS_AXI_AW-1:0] next_aw_addr_q;
    logic [31:0] next_w_data_q;
    logic [3:0] next_w_strb_q;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_soft_sleep;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [31:0] status_word;

    // Status word from live state
    always_comb begin
        status_word = '0;
        status_word[SBS_ST_ASLEEP_BIT] = strap[SBS_STRAP_ZZ_BIT] | soft_sleep;
        status_word[SBS_ST_PIPE_BIT] = pipelined;
        status_word[SBS_ST_INTERLEAVE_BIT] = interleaved;
        status_word[SBS_ST_DRIVE_BIT] = drive;
        status_word[SBS_ST_LIVE_BIT] = live;
        status_word[SBS_ST_LOW_LSB +: 2] = bif.low_now;
    end

    // AW and W in any order, then B
    always_comb begin
        next_aw_have = aw_have;
        next_w_have = w_have;
        next_aw_addr_q = aw_addr_q;
        next_w_data_q = w_data_q;
        next_w_strb_q = w_strb_q;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_soft_sleep = soft_sleep;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_have = 1'b1;
            next_aw_addr_q = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_have = 1'b1;
            next_w_data_q = s_axi_wdata;
            next_w_strb_q = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_have && w_have && !s_axi_bvalid) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = SBS_RESP_OKAY;
            if (aw_addr_q[SBS_AXI_AW-1:2] == SBS_CTRL_OFFSET[SBS_AXI_AW-1:2]) begin
                if (w_strb_q[0]) begin
                    next_soft_sleep = w_data_q[SBS_CTRL_SLEEP_BIT];
                end
            end else begin
                next_bresp = SBS_RESP_SLVERR;
            end
        end
        next_awready = !next_aw_have && !next_bvalid;
        next_wready = !next_w_have && !next_bvalid;
    end

    // Reads answer a cycle after AR
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = SBS_RESP_OKAY;
            if (s_axi_araddr[SBS_AXI_AW-1:2] == SBS_CTRL_OFFSET[SBS_AXI_AW-1:2]) begin
                next_rdata = {31'h0, soft_sleep};
            end else if (s_axi_araddr[SBS_AXI_AW-1:2] == SBS_STATUS_OFFSET[SBS_AXI_AW-1:2]) begin
                next_rdata = status_word;
            end else begin
                next_rdata = '0;
                next_rresp = SBS_RESP_SLVERR;
            end
        end
        next_arready = !next_rvalid;
    end

    // Register the slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SBS_RESP_OKAY;
            soft_sleep <= SBS_CTRL_SLEEP_RESET;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= SBS_RESP_OKAY;
        end else begin
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            aw_addr_q <= next_aw_addr_q;
            w_data_q <= next_w_data_q;
            w_strb_q <= next_w_strb_q;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            soft_sleep <= next_soft_sleep;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule : sbs_core
`default_nettype wire

// ===== include/sbs_pkg.sv
// Constants and types for the burst memory core
package sbs_pkg;

    // ==========================================================
    // Array geometry
    localparam int SBS_ADDR_W = 16;
    localparam int SBS_DATA_W = 32;
    localparam int SBS_LANES = 4;
    localparam int SBS_LANE_W = 8;
    localparam logic [3:0] SBS_LANES_ALL = 4'hF;
    localparam logic [3:0] SBS_LANES_NONE = 4'h0;

    // ==========================================================
    // Mode strap synchroniser: bit order {sleep, order, flow}
    localparam int SBS_STRAP_W = 3;
    localparam int SBS_STRAP_FT_BIT = 0;
    localparam int SBS_STRAP_LBO_BIT = 1;
    localparam int SBS_STRAP_ZZ_BIT = 2;
    localparam logic [2:0] SBS_STRAP_RESET = 3'h3;

    // ==========================================================
    // Control register map
    localparam int SBS_AXI_AW = 8;
    localparam logic [7:0] SBS_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SBS_STATUS_OFFSET = 8'h04;
    localparam int SBS_CTRL_SLEEP_BIT = 0;
    localparam logic SBS_CTRL_SLEEP_RESET = 1'b0;
    localparam int SBS_ST_ASLEEP_BIT = 0;
    localparam int SBS_ST_PIPE_BIT = 1;
    localparam int SBS_ST_INTERLEAVE_BIT = 2;
    localparam int SBS_ST_DRIVE_BIT = 3;
    localparam int SBS_ST_LIVE_BIT = 4;
    localparam int SBS_ST_LOW_LSB = 8;
    localparam logic [1:0] SBS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SBS_RESP_SLVERR = 2'h2;

    // ==========================================================
    // Counter index and access kinds
    localparam logic [1:0] SBS_INDEX_START = 2'h0;
    localparam logic [1:0] SBS_INDEX_STEP = 2'h1;
    typedef enum logic [1:0] {
        SBS_OP_IDLE,
        SBS_OP_DESELECT,
        SBS_OP_READ,
        SBS_OP_WRITE
    } sbs_op_type;

endpackage : sbs_pkg

// ===== include/sbs_burst_if.sv
// Decoder to burst counter link
`timescale 1ns/1ns
`default_nettype none
interface sbs_burst_if;
    logic load;
    logic step;
    logic linear;
    logic [1:0] start_low;
    logic [1:0] low_now;

    // ==========================================================
    // Decoder and counter ends
    modport ctrl (output load, output step, output linear, output start_low, input low_now);
    modport counter (input load, input step, input linear, input start_low, output low_now);
endinterface : sbs_burst_if
`default_nettype wire

// ===== verilog/sbs_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module sbs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Levels
    input wire logic [WIDTH-1:0] pin_level,
    output logic [WIDTH-1:0] level
);

    // ==========================================================
    // Chain and filter
    logic [WIDTH-1:0] stage1, stage2, stage3;
    logic [WIDTH-1:0] next_level;

    if (WIDTH < 1) begin : g_check
        $error("sbs_sync needs WIDTH of at least one");
    end

    // Accept a change once the last two stages agree
    always_comb begin
        next_level = level;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_level[i] = stage3[i];
            end
        end
    end

    // Register the chain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
            level <= RESET_VAL;
        end else begin
            stage1 <= pin_level;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end

endmodule : sbs_sync
`default_nettype wire

// ===== verilog/sbs_burst_counter.sv
// Two-bit burst address counter, linear or interleaved order
`timescale 1ns/1ns
`default_nettype none
module sbs_burst_counter
    import sbs_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Decoder link
    sbs_burst_if.counter bif
);

    // ==========================================================
    // Counter state
    logic [1:0] start;
    logic [1:0] index;
    logic [1:0] next_start;
    logic [1:0] next_index;
    logic [1:0] index_use;

    // Preset on burst start, step on advance, wrap after four
    always_comb begin
        index_use = bif.step ? index + SBS_INDEX_STEP : index;
        next_start = bif.load ? bif.start_low : start;
        next_index = bif.load ? SBS_INDEX_START : index_use;
        if (bif.linear) begin
            bif.low_now = start + index_use;
        end else begin
            bif.low_now = start ^ index_use;
        end
    end

    // Register the counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start <= SBS_INDEX_START;
            index <= SBS_INDEX_START;
        end else begin
            start <= next_start;
            index <= next_index;
        end
    end

endmodule : sbs_burst_counter
`default_nettype wire

// ===== verification/sbs_core_properties.sv
// Pin property checker for the memory core
`timescale 1ns/1ns
`default_nettype none
module sbs_core_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins watched
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic strobe_processor_n,
    input wire logic strobe_cache_n,
    input wire logic byte_write_enable_n,
    input wire logic all_bytes_write_n,
    input wire logic [3:0] lane_write_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic [3:0] data_oe_n
);
    logic pgo, cgo, sel, wr, go, wgo, dgo, cont;

    // ====
    // Command decode
    assign pgo = !strobe_processor_n && !chip_select_first_n;
    assign cgo = !pgo && !strobe_cache_n;
    assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
    assign wr = !all_bytes_write_n || (!byte_write_enable_n && lane_write_n != 4'hF);
    assign go = !sleep_request && sel && (pgo || (cgo && !wr));
    assign wgo = !sleep_request && sel && cgo && wr;
    assign dgo = !sleep_request && !sel && (pgo || cgo);
    assign cont = strobe_processor_n && strobe_cache_n && !wr
        && !output_enable_n && !sleep_request;

    // ====
    // Driver properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_OE_OFF: assert property (output_enable_n |-> data_oe_n == 4'hF)
        else $error("oe high but driving");
    AST_SLEEP_OFF: assert property (sleep_request |-> data_oe_n == 4'hF)
        else $error("drivers on in sleep");
    AST_ALL_LANES: assert property (data_oe_n == 4'h0 || data_oe_n == 4'hF)
        else $error("uneven lanes");
    AST_WRITE_HIZ: assert property (wgo |=> data_oe_n == 4'hF)
        else $error("drivers on after write");
    AST_DESEL_OFF: assert property (dgo && chip_select_third_n |=> data_oe_n == 4'hF)
        else $error("drivers on after deselect");
    AST_SEL_SECOND: assert property (dgo && !chip_select_second |=> data_oe_n == 4'hF)
        else $error("select two low kept driving");
    AST_READ_DRIVE: assert property (go ##1 cont [*2] |-> data_oe_n == 4'h0)
        else $error("read drive late");
    AST_ON_CAUSE: assert property ($fell(data_oe_n[0]) |-> !output_enable_n)
        else $error("drive began with oe high");
    COV_READ: cover property (go ##1 cont [*2]);
    COV_WRITE: cover property (wgo);
    COV_DESEL: cover property (dgo);
endmodule : sbs_core_properties
bind sbs_core sbs_core_properties sbs_core_properties_inst (
    .aclk, .aresetn, .chip_select_first_n, .chip_select_second, .chip_select_third_n,
    .strobe_processor_n, .strobe_cache_n, .byte_write_enable_n, .all_bytes_write_n,
    .lane_write_n, .output_enable_n, .sleep_request, .data_oe_n
);
`default_nettype wire

// ===== verification/sbs_ctrl_model.sv
// Controller model for the memory pins
`timescale 1ns/1ns
`default_nettype none
module sbs_ctrl_model (
    // Clock
    input wire logic aclk,
    // Pins toward the core
    output logic [15:0] addr,
    output logic chip_select_first_n,
    output logic chip_select_second,
    output logic chip_select_third_n,
    output logic strobe_processor_n,
    output logic strobe_cache_n,
    output logic burst_step_n,
    output logic byte_write_enable_n,
    output logic all_bytes_write_n,
    output logic [3:0] lane_write_n,
    // Shared data bus
    input wire logic [31:0] data_out,
    input wire logic [3:0] data_oe_n,
    output logic [31:0] data_in
);
    logic [31:0] wd;

    // Bus level per lane
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            data_in[8*i+:8] = data_oe_n[i] ? wd[8*i+:8] : data_out[8*i+:8];
        end
    end

    // Idle, deselected at start
    initial begin
        {strobe_processor_n, strobe_cache_n, burst_step_n, chip_select_first_n} = 4'hF;
        {chip_select_second, chip_select_third_n, all_bytes_write_n, byte_write_enable_n} = 4'h7;
        lane_write_n = 4'hF;
        addr = 16'h0000;
        wd = 32'h0;
    end

    // One pin cycle after an edge
    task automatic cyc(input logic ps, cc, st, sel, gw, bw, input logic [3:0] ln,
        input logic [15:0] a, input logic [31:0] d);
        @(posedge aclk);
        strobe_processor_n <= ps;
        strobe_cache_n <= cc;
        burst_step_n <= st;
        chip_select_first_n <= !sel;
        chip_select_second <= sel;
        chip_select_third_n <= !sel;
        all_bytes_write_n <= gw;
        byte_write_enable_n <= bw;
        lane_write_n <= ln;
        addr <= a;
        // Idle bus shows inverted data
        wd <= (!gw || !bw) ? d : ~wd;
    endtask : cyc
endmodule : sbs_ctrl_model
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the burst memory core
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import sbs_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0, output_enable_n = 1'h0, sleep_request = 1'h0;
    logic flow_through_select_n = 1'h1, linear_order_n = 1'h1;
    logic [15:0] addr;
    logic [31:0] data_in, data_out, v;
    logic [3:0] lane_write_n, data_oe_n;
    logic [1:0] r, j;
    logic chip_select_first_n, chip_select_second, chip_select_third_n, strobe_processor_n;
    logic strobe_cache_n, burst_step_n, byte_write_enable_n, all_bytes_write_n;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] mem [4] = '{32'h5A5A0000, 32'h5A5A0001, 32'h5A5A0002, 32'h5A5AFF03};
    int n_fail = 0, checks_done = 0;

    // Clock and instances
    always #5 aclk = ~aclk;
    sbs_core sbs_core_inst (
        .aclk, .aresetn, .addr, .chip_select_first_n, .chip_select_second,
        .chip_select_third_n, .strobe_processor_n, .strobe_cache_n, .burst_step_n,
        .byte_write_enable_n, .all_bytes_write_n, .lane_write_n, .output_enable_n,
        .flow_through_select_n, .linear_order_n, .sleep_request, .data_in, .data_out,
        .data_oe_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    sbs_ctrl_model ctl (
        .aclk, .addr, .chip_select_first_n, .chip_select_second, .chip_select_third_n,
        .strobe_processor_n, .strobe_cache_n, .burst_step_n, .byte_write_enable_n,
        .all_bytes_write_n, .lane_write_n, .data_out, .data_oe_n, .data_in
    );

    // Compare and verdict
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_of_test(input int lost);
        n_fail += lost;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Register bus master
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        if (n == 50) end_of_test(1);
        chk("bresp", s_axi_bresp, er);
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        if (n == 50) end_of_test(1);
        d = s_axi_rdata;
        rr = s_axi_rresp;
    endtask : axr

    // Pin cycle shorthands
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic gw,
        input logic [3:0] ln);
        ctl.cyc(1'h1, 1'h0, 1'h1, 1'h1, gw, ~gw, ln, a, d);
    endtask : wr
    task automatic desel();
        ctl.cyc(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 4'hF, 16'h0, 32'h0);
    endtask : desel
    task automatic cont(input logic st);
        ctl.cyc(1'h1, 1'h1, st, 1'h1, 1'h1, 1'h1, 4'hF, 16'h0, 32'h0);
    endtask : cont
    task automatic look(input logic [31:0] ed, input logic [3:0] eo);
        #1;
        chk("data_out", data_out, ed);
        chk("data_oe_n", data_oe_n, eo);
    endtask : look
    task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
        ctl.cyc(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, a, 32'h0);
        cont(1'h1);
        cont(1'h1);
        look(e, 4'h0);
        desel();
        look(e, 4'h0);
        desel();
        look(32'h0, 4'hF);
    endtask : rdchk

    // Main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (6) @(posedge aclk);
        axr(SBS_STATUS_OFFSET, v, r);
        chk("straps", v[2:0], 3'h6);
        axr(8'h08, v, r);
        chk("unmapped", {r, v[29:0]}, {SBS_RESP_SLVERR, 30'h0});
        axw(8'h0C, 32'h1, SBS_RESP_SLVERR);
        $display("test regs done");
        for (int i = 0; i < 4; i++) ctl.cyc(1'h1, i > 0, i == 0, 1'h1, 1'h0, 1'h1, 4'hF,
            16'h0120, {30'h16968000, i[1:0]});
        wr(16'h0123, 32'hFFFFFFFF, 1'h1, 4'hD);
        look(32'h0, 4'hF);
        wr(16'h0122, 32'h0, 1'h1, 4'hF);
        ctl.cyc(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 4'hF, 16'h0120, 32'h0);
        rdchk(16'h0123, mem[3]);
        rdchk(16'h0122, mem[2]);
        rdchk(16'h0120, mem[0]);
        $display("test writes done");
        for (int s = 0; s < 2; s++) begin
            if (s == 0) @(posedge aclk) sleep_request <= 1'h1;
            else axw(SBS_CTRL_OFFSET, 32'h1, SBS_RESP_OKAY);
            axr(SBS_CTRL_OFFSET, v, r);
            chk("ctrl", v, s);
            wr(16'h0121, 32'h0, 1'h0, 4'hF);
            desel();
            look(32'h0, 4'hF);
            @(posedge aclk) sleep_request <= 1'h0;
            axw(SBS_CTRL_OFFSET, 32'h0, SBS_RESP_OKAY);
            rdchk(16'h0121, mem[1]);
        end
        $display("test sleep done");
        @(posedge aclk) flow_through_select_n <= 1'h0;
        for (int o = 0; o < 2; o++) begin
            @(posedge aclk) linear_order_n <= o[0];
            repeat (8) desel();
            ctl.cyc(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, 16'h0121, 32'h0);
            for (int k = 0; k < 5; k++) begin
                cont(1'h0);
                output_enable_n <= (k == 2);
                j = o ? 2'h1 ^ k[1:0] : 2'h1 + k[1:0];
                look(mem[j], (k == 2) ? 4'hF : 4'h0);
            end
            desel();
        end
        $display("test bursts done");
        end_of_test(0);
    end
endmodule : tb_top
`default_nettype wire
